// ==== common/eeprom_slave_regs.svh ====
`ifndef EEPROM_SLAVE_REGS_SVH
`define EEPROM_SLAVE_REGS_SVH

// Slave address layout
`define DEV_TYPE_CODE 4'ha
`define SLV_TYPE_MSB 7
`define SLV_TYPE_LSB 4
`define SLV_CS_TWO_BIT 3
`define SLV_CS_ONE_BIT 2
`define SLV_BLOCK_BIT 1
`define SLV_DIR_BIT 0

// Memory organisation
`define ARRAY_LOCATIONS 256
`define WRITE_PAGE_BYTES 16
`define PAGE_BLOCK_BITS 2048

// Timing
`define CLK_PERIOD_PS 5000
`define PROGRAM_CYCLE_TIME_US 10000
// Scaled in two steps so the product stays inside a 32-bit int
`define PROGRAM_CYCLE_CYCLES ((`PROGRAM_CYCLE_TIME_US * 1000) / (`CLK_PERIOD_PS / 1000))

`endif

// ==== common/eeprom_slave_pkg.sv ====
package eeprom_slave_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_WORD = 7'h04,
    ST_WDATA = 7'h08,
    ST_RDATA = 7'h10,
    ST_ACK = 7'h20,
    ST_WAIT_STOP = 7'h40
  } slave_state_e;

  typedef logic [7:0] byte_t;

endpackage : eeprom_slave_pkg

// ==== verilog/byte_fifo.sv ====
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("byte_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] wr_ptr_nxt;
  logic [AW:0] rd_ptr_nxt;
  logic full;
  logic empty;
  logic push;
  logic pop;

  always_comb begin
    full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    empty = (wr_ptr_r == rd_ptr_r);
    in_ready = !full;
    out_valid = !empty;
    push = in_valid && !full;
    pop = out_ready && !empty;
    wr_ptr_nxt = wr_ptr_r + (AW + 1)'(push);
    rd_ptr_nxt = rd_ptr_r + (AW + 1)'(pop);
    out_data = mem_r[rd_ptr_r[AW-1:0]];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (clk_en) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      if (push) begin
        mem_r[wr_ptr_r[AW-1:0]] <= in_data;
      end
    end
  end
endmodule : byte_fifo

// ==== verilog/eeprom_two_wire_slave_interface.sv ====
// Functional notes
// - Receiver pulls data low for the whole ninth clock, then releases it.
// - Transmitter releases data after eight bits and samples the acknowledge.
// - Byte after a write address is the 8-bit array address.
// - Array address picks one of 256 bytes; block bit extends it.
// - Write pages are 16 bytes aligned on 16-byte boundaries.
// - Each page block holds 2048 bits: 16 pages of 16 bytes.
// - Data line is open drain: pull low or release only.
// - Write protect high blocks programming of the upper half.
// - Protected write: address bytes acknowledged, data byte not.
// - Undriven write protect reads as low, unprotected.
// - Chip-select inputs must match their slave address bits.
// - Lowest selection bit chooses the page block, not a pin.
// - Data changes with clock low are data; with clock high, start/stop.
// - Watch for start except while programming; ignore the bus until one occurs.
// - Stop ends the transaction; standby unless a write is pending.
// - After a write-launching stop, standby needs a later stop.
// - Acknowledge a start followed by a matching slave address.
// - Acknowledge every written byte except protected data bytes and data bytes that find the buffer full.
// - In read, release after eight bits, next byte on master acknowledge.
// - Master no-acknowledge stops transmission until a stop arrives.
// - Slave address: 4-bit type, three selection bits, direction bit.
// - Respond only to device type 1010.
// - Direction one is read, zero is write.
// - During programming the bus side is off and address not acknowledged.
`timescale 1ns/1ps
`include "eeprom_slave_regs.svh"
module eeprom_two_wire_slave_interface
  import eeprom_slave_pkg::*;
#(
  parameter int PROGRAM_CYCLE_CYCLES = `PROGRAM_CYCLE_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Two-wire pins; the clock is input only
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic chip_select_input_one,
  input wire logic chip_select_input_two,
  input wire logic write_protect,
  // Write stream to the array: {block, address, data}
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [16:0] wr_data,
  output logic wr_commit,
  // Read data source: array supplies the byte at rd_addr
  output logic [8:0] rd_addr,
  output logic rd_req,
  input wire logic [7:0] rd_byte,
  output logic busy,
  output logic selected
);

  initial begin
    if (PROGRAM_CYCLE_CYCLES < 1 || FIFO_DEPTH < 2) begin
      $error("eeprom_two_wire_slave_interface: bad parameter");
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins are asynchronous to clk_sys, so two flops before any use
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] wp_sync_r;
  logic [1:0] cs1_sync_r;
  logic [1:0] cs2_sync_r;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      wp_sync_r <= 2'h0;
      cs1_sync_r <= 2'h0;
      cs2_sync_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (clk_en) begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      wp_sync_r <= {wp_sync_r[0], write_protect};
      cs1_sync_r <= {cs1_sync_r[0], chip_select_input_one};
      cs2_sync_r <= {cs2_sync_r[0], chip_select_input_two};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_comb begin
    scl_s = scl_sync_r[1];
    sda_s = sda_sync_r[1];
    scl_rise = scl_s && !scl_d_r;
    scl_fall = !scl_s && scl_d_r;
    // Data edges with clock high are conditions only, never data
    start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
  end

  // ---------------------------------------------------------------
  // Protocol state
  // ---------------------------------------------------------------
  slave_state_e state_r, state_nxt;
  slave_state_e after_ack_r, after_ack_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  byte_t shift_r, shift_nxt;
  logic [7:0] word_addr_r, word_addr_nxt;
  logic block_r, block_nxt;
  logic ack_drive_r, ack_drive_nxt;
  logic drive_low_r, drive_low_nxt;
  logic wr_pending_r, wr_pending_nxt;
  logic standby_hold_r, standby_hold_nxt;
  logic [31:0] busy_cnt_r, busy_cnt_nxt;
  logic fifo_push;
  logic fifo_in_ready;
  logic addr_match;
  logic upper_protected;

  always_comb begin
    // Pins present are compared; the block bit is not
    addr_match = (shift_r[`SLV_TYPE_MSB:`SLV_TYPE_LSB] == `DEV_TYPE_CODE) &&
                 (shift_r[`SLV_CS_TWO_BIT] == cs2_sync_r[1]) &&
                 (shift_r[`SLV_CS_ONE_BIT] == cs1_sync_r[1]);
    // Upper half is block 1 of the two 256-byte blocks
    upper_protected = wp_sync_r[1] && block_r;
  end

  always_comb begin
    state_nxt = state_r;
    after_ack_nxt = after_ack_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    word_addr_nxt = word_addr_r;
    block_nxt = block_r;
    ack_drive_nxt = ack_drive_r;
    drive_low_nxt = drive_low_r;
    wr_pending_nxt = wr_pending_r;
    standby_hold_nxt = standby_hold_r;
    busy_cnt_nxt = busy_cnt_r;
    fifo_push = 1'b0;

    if (busy_cnt_r != 32'h0) begin
      busy_cnt_nxt = busy_cnt_r - 32'h1;
    end

    if (busy_cnt_r != 32'h0) begin
      // Interface off while programming: line released, only a stop is decoded
      state_nxt = ST_IDLE;
      drive_low_nxt = 1'b0;
      if (stop_det) begin
        standby_hold_nxt = 1'b1;
      end
    end else if (start_det) begin
      // Start anywhere, even mid-byte, restarts address reception
      state_nxt = ST_ADDR;
      bit_cnt_nxt = 4'h0;
      drive_low_nxt = 1'b0;
    end else if (stop_det) begin
      drive_low_nxt = 1'b0;
      state_nxt = ST_IDLE;
      if (wr_pending_r) begin
        busy_cnt_nxt = PROGRAM_CYCLE_CYCLES;
        wr_pending_nxt = 1'b0;
        // Only a stop after the program time may return to standby
        standby_hold_nxt = 1'b1;
      end else begin
        standby_hold_nxt = 1'b0;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          drive_low_nxt = 1'b0;
        end
        ST_ADDR, ST_WORD, ST_WDATA: begin
          if (scl_rise && bit_cnt_r < 4'h8) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_nxt = 4'h0;
            ack_drive_nxt = 1'b0;
            after_ack_nxt = ST_IDLE;
            if (state_r == ST_ADDR) begin
              if (addr_match) begin
                ack_drive_nxt = 1'b1;
                block_nxt = shift_r[`SLV_BLOCK_BIT];
                after_ack_nxt = shift_r[`SLV_DIR_BIT] ? ST_RDATA : ST_WORD;
              end
            end else if (state_r == ST_WORD) begin
              word_addr_nxt = shift_r;
              ack_drive_nxt = 1'b1;
              after_ack_nxt = ST_WDATA;
            end else if (!upper_protected && fifo_in_ready) begin
              fifo_push = 1'b1;
              wr_pending_nxt = 1'b1;
              // Roll over within the 16-byte write page
              word_addr_nxt = {word_addr_r[7:4], word_addr_r[3:0] + 4'h1};
              ack_drive_nxt = 1'b1;
              after_ack_nxt = ST_WDATA;
            end else begin
              // Protected data byte or full buffer: no acknowledge, byte not queued
              ack_drive_nxt = 1'b0;
            end
            drive_low_nxt = ack_drive_nxt;
            state_nxt = ST_ACK;
          end
        end
        ST_ACK: begin
          // Hold the acknowledge through the whole ninth clock
          if (scl_fall) begin
            drive_low_nxt = 1'b0;
            state_nxt = after_ack_r;
            if (after_ack_r == ST_RDATA) begin
              shift_nxt = rd_byte;
              drive_low_nxt = !rd_byte[7];
              bit_cnt_nxt = 4'h1;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall && bit_cnt_r < 4'h8) begin
            drive_low_nxt = !shift_r[3'(7 - bit_cnt_r)];
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            drive_low_nxt = 1'b0;
            bit_cnt_nxt = 4'h9;
          end else if (scl_rise && bit_cnt_r == 4'h9) begin
            word_addr_nxt = word_addr_r + 8'h1;
            if (word_addr_r == 8'hff) begin
              block_nxt = !block_r;
            end
            if (sda_s) begin
              state_nxt = ST_WAIT_STOP;
            end else begin
              bit_cnt_nxt = 4'ha;
            end
          end else if (scl_fall && bit_cnt_r == 4'ha) begin
            shift_nxt = rd_byte;
            drive_low_nxt = !rd_byte[7];
            bit_cnt_nxt = 4'h1;
          end
        end
        ST_WAIT_STOP: begin
          drive_low_nxt = 1'b0;
        end
        default: begin
          state_nxt = ST_IDLE;
          drive_low_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      word_addr_r <= 8'h00;
      block_r <= 1'b0;
      ack_drive_r <= 1'b0;
      drive_low_r <= 1'b0;
      wr_pending_r <= 1'b0;
      standby_hold_r <= 1'b0;
      busy_cnt_r <= 32'h0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      after_ack_r <= after_ack_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      word_addr_r <= word_addr_nxt;
      block_r <= block_nxt;
      ack_drive_r <= ack_drive_nxt;
      drive_low_r <= drive_low_nxt;
      wr_pending_r <= wr_pending_nxt;
      standby_hold_r <= standby_hold_nxt;
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Open drain: output value is always low, only the enable moves
  always_comb begin
    sda_out = 1'b0;
    sda_oe_n = !drive_low_r;
    rd_addr = {block_r, word_addr_r};
    rd_req = (state_r == ST_RDATA) || (after_ack_r == ST_RDATA);
    busy = (busy_cnt_r != 32'h0) || standby_hold_r;
    selected = (state_r != ST_IDLE) && (state_r != ST_ADDR);
    wr_commit = stop_det && wr_pending_r && (busy_cnt_r == 32'h0);
  end

  // Buffered write bytes; a full buffer refuses acknowledge
  byte_fifo #(
    .WIDTH(17),
    .DEPTH(FIFO_DEPTH)
  ) byte_fifo_inst (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({block_r, word_addr_r, shift_r}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

endmodule : eeprom_two_wire_slave_interface

// ==== verification/slave_monitor.sv ====
`timescale 1ns/1ps
module slave_monitor #(
  parameter int PROGRAM_CYCLE_CYCLES = 50
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [16:0] wr_data,
  input wire logic wr_commit,
  input wire logic busy
);
  // ------
  // Program cycle timer, restarted by each commit
  // ------
  int prog_r;
  int prog_nxt;
  always_comb prog_nxt = wr_commit ? PROGRAM_CYCLE_CYCLES : (prog_r != 0 ? prog_r - 1 : 0);
  always_ff @(posedge clk_sys) prog_r <= resetn ? prog_nxt : 0;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda_out high");
  a_scl_low_change: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda drive moved with scl high");
  a_ack_held: assert property (!sda_oe_n && scl_in |=> !sda_oe_n)
    else $error("sda released with scl high");
  a_commit_pulse: assert property (wr_commit |=> !wr_commit)
    else $error("commit too long");
  a_commit_stop: assert property (wr_commit |-> scl_in && sda_in && $past(scl_in, 2))
    else $error("commit without stop");
  a_busy_follows: assert property (wr_commit |=> busy [*8])
    else $error("busy not raised");
  a_quiet_program: assert property (prog_r > 1 |-> sda_oe_n)
    else $error("sda pulled while programming");
  a_busy_span: assert property (prog_r > 1 |-> busy)
    else $error("busy dropped early");
  a_fifo_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write stream moved while stalled");
endmodule : slave_monitor

// ==== verification/two_wire_master.sv ====
`timescale 1ns/1ps
module two_wire_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_bus
);
  localparam int Q = 40;
  // ------
  // Bus master: owns the clock and leaves it high between frames
  // ------
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic clk_bit(input logic b, output logic r);
    sda_drv = b;
    #Q scl = 1'b1;
    #Q r = sda_bus;
    #Q scl = 1'b0;
    #Q;
  endtask : clk_bit
  task automatic start_c;
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_c
  // Only after a frame: with the clock high this would be a start
  task automatic stop_c;
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop_c
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = (r === 1'b0);
  endtask : put_byte
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(~mack, r);
  endtask : get_byte
endmodule : two_wire_master

// ==== verification/test_eeprom_two_wire_slave_interface.sv ====
`timescale 1ns/1ps
module test_eeprom_two_wire_slave_interface;
  import eeprom_slave_pkg::*;
  localparam int PCC = 600;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wr_ready = 1'b1;
  logic wp_drv = 1'b0;
  logic scl_in, m_sda, sda_out, sda_oe_n, wr_valid, wr_commit, rd_req, busy, selected;
  logic [16:0] wr_data;
  logic [8:0] rd_addr;
  byte_t rd_byte;
  logic [16:0] popq[$];
  int n_mismatch = 0;
  int check_count = 0;
  // Pull-up on the data line; anyone may pull it low
  wire logic sda_in = m_sda & (sda_oe_n | sda_out);
  // Pad pull-down: a floating protect pin settles low
  wire logic write_protect = (wp_drv === 1'bz) ? 1'b0 : wp_drv;
  assign rd_byte = rd_addr[7:0] + 8'h3c;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (resetn && wr_valid && wr_ready) popq.push_back(wr_data);
  eeprom_two_wire_slave_interface #(.PROGRAM_CYCLE_CYCLES(PCC))
      eeprom_two_wire_slave_interface_inst (
    .clk_sys, .resetn, .clk_en(1'b1), .scl_in, .sda_in, .sda_out, .sda_oe_n,
    .chip_select_input_one(1'b0), .chip_select_input_two(1'b1), .write_protect,
    .wr_valid, .wr_ready, .wr_data, .wr_commit, .rd_addr, .rd_req, .rd_byte, .busy, .selected);
  two_wire_master mst (.scl(scl_in), .sda_drv(m_sda), .sda_bus(sda_in));
  // ------
  // Shared checks and frames
  // ------
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic addr_only(input byte_t a, output logic k);
    mst.start_c();
    mst.put_byte(a, k);
    mst.stop_c();
  endtask : addr_only
  task automatic wr3(input byte_t a, input byte_t w, input byte_t d, output logic [2:0] k);
    mst.start_c();
    mst.put_byte(a, k[2]);
    mst.put_byte(w, k[1]);
    mst.put_byte(d, k[0]);
    mst.stop_c();
  endtask : wr3
  // Standby needs one more stop once the program time is over
  task automatic settle;
    repeat (PCC + 10) @(posedge clk_sys);
    #1;
    mst.start_c();
    mst.stop_c();
  endtask : settle
  // ------
  // Scenarios
  // ------
  task automatic t_write_poll;
    logic [2:0] k;
    logic p;
    popq.delete();
    wr3(8'ha8, 8'h05, 8'ha5, k);
    chk(k === 3'b111, "byte write acks");
    chk(busy === 1'b1, "busy not raised");
    addr_only(8'ha8, p);
    chk(p === 1'b0, "ack while programming");
    repeat (PCC + 10) @(posedge clk_sys);
    #1;
    chk(busy === 1'b1, "standby before second stop");
    mst.start_c();
    mst.stop_c();
    chk(busy === 1'b0, "no standby after second stop");
    addr_only(8'ha8, p);
    chk(p === 1'b1, "no ack after program");
    chk(popq.size() == 1 && popq[0] === 17'h005a5, "stored word");
  endtask : t_write_poll
  task automatic t_select;
    byte_t tbl[6] = '{8'ha8, 8'haa, 8'hac, 8'ha0, 8'hb8, 8'h28};
    logic p;
    for (int i = 0; i < 6; i++) begin
      addr_only(tbl[i], p);
      chk(p === (i < 2), "address match");
    end
  endtask : t_select
  task automatic t_protect;
    logic [2:0] k;
    popq.delete();
    wp_drv = 1'b1;
    wr3(8'haa, 8'h30, 8'h77, k);
    chk(k === 3'b110, "protected data acked");
    wr3(8'ha8, 8'h30, 8'h77, k);
    chk(k === 3'b111, "lower half refused");
    settle();
    wp_drv = 1'bz;
    wr3(8'haa, 8'h31, 8'h78, k);
    chk(k === 3'b111, "floating protect refused");
    settle();
    wp_drv = 1'b0;
    chk(popq.size() == 2 && popq[1] === 17'h13178, "upper block word");
  endtask : t_protect
  task automatic t_read;
    logic [2:0] k;
    byte_t b0, b1, b2;
    mst.start_c();
    mst.put_byte(8'ha8, k[2]);
    mst.put_byte(8'h10, k[1]);
    mst.start_c();
    mst.put_byte(8'ha9, k[0]);
    chk(k === 3'b111, "read setup acks");
    chk(selected === 1'b1, "not selected in read");
    mst.get_byte(1'b1, b0);
    mst.get_byte(1'b0, b1);
    mst.get_byte(1'b1, b2);
    mst.stop_c();
    chk(selected === 1'b0, "selected after stop");
    chk(b0 === 8'h4c && b1 === 8'h4d, "read data");
    chk(b2 === 8'hff, "sent after no ack");
  endtask : t_read
  task automatic t_abort;
    logic r;
    mst.start_c();
    repeat (4) mst.clk_bit(1'b1, r);
    addr_only(8'ha8, r);
    chk(r === 1'b1, "restart inside byte");
  endtask : t_abort
  task automatic t_fifo;
    logic a;
    popq.delete();
    wr_ready = 1'b0;
    mst.start_c();
    mst.put_byte(8'ha8, a);
    mst.put_byte(8'h1c, a);
    for (int i = 0; i < 9; i++) begin
      mst.put_byte(8'(8'h60 + i), a);
      chk(a === (i < 8), "full buffer ack");
    end
    mst.stop_c();
    wr_ready = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    chk(popq.size() == 8, "drain count");
    for (int i = 0; i < 8; i++)
      chk(popq[i] === {5'h01, 4'(12 + i), 8'(8'h60 + i)}, "page roll");
    settle();
  endtask : t_fifo
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_write_poll();
    t_select();
    t_protect();
    t_read();
    t_abort();
    t_fifo();
    final_report();
  end
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule : test_eeprom_two_wire_slave_interface
bind eeprom_two_wire_slave_interface slave_monitor #(
  .PROGRAM_CYCLE_CYCLES(PROGRAM_CYCLE_CYCLES)
) mon (.clk_sys, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe_n,
  .wr_valid, .wr_ready, .wr_data, .wr_commit, .busy);
